// [wdrt_cfg.svh]
// Constants for the watchdog reset timer: offsets, keys, counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef WDRT_CFG_SVH
`define WDRT_CFG_SVH

// Register map; the key register's printed offset is a word index
`define WDRT_SERVICE_KEY_IDX  8'ha6
// Byte address of the key register: four times its index
`define WDRT_SERVICE_KEY_OFF  12'h0298
`define WDRT_STATUS_OFF       12'h0100
`define WDRT_CONTROL_OFF      12'h0104

// Service key bytes
`define WDRT_KEY_FIRST        8'h1e
`define WDRT_KEY_SECOND       8'he1

// Counter geometry
`define WDRT_CNT_WIDTH        14
`define WDRT_CNT_TERMINAL     14'h3fff

// Machine cycle and reset pulse, in oscillator periods
`define WDRT_OSC_PER_MCYCLE   12
`define WDRT_RST_PULSE_OSC    98

// Control field positions
`define WDRT_CTL_PDOWN_BIT    0
`define WDRT_CTL_WAKE_BIT     1

// Status field positions
`define WDRT_STS_ARMED_BIT    0
`define WDRT_STS_HALTED_BIT   1
`define WDRT_STS_PULSE_BIT    2
`define WDRT_STS_KEYHALF_BIT  3

`endif

// [wdrt_pkg.sv]
// Types for the watchdog reset timer.
// Assumes wdrt_cfg.svh is on the include path.
`include "wdrt_cfg.svh"

package wdrt_pkg;

  // Key sequence tracker
  typedef enum logic [0:0] {
    WDRT_KEY_IDLE,
    WDRT_KEY_HALF
  } wdrt_key_t;

  // AHB-Lite slave state
  typedef struct packed {
    logic        pend;
    logic        write;
    logic [11:0] addr;
    logic [31:0] rdata;
  } wdrt_bus_t;

endpackage : wdrt_pkg

// [wdrt_pulse.sv]
// Reset pulse stretcher: one trigger makes a fixed-length high pulse.
// Assumes the trigger is a one-cycle pulse on the same clock.
module wdrt_pulse #(
  parameter int unsigned LENGTH = 98
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Trigger and pulse
  input  wire logic trigger,
  output logic      pulse
);

  localparam int unsigned CW = $clog2(LENGTH + 1);

  typedef struct packed {
    logic          on;
    logic [CW-1:0] cnt;
  } wdrt_pulse_st_t;

  wdrt_pulse_st_t st_reg;
  wdrt_pulse_st_t st_next;

  // Load the count on trigger, count down while high
  always_comb begin
    st_next = st_reg;
    if (trigger) begin
      st_next.on  = 1'b1;
      st_next.cnt = CW'(LENGTH - 1);
    end else if (st_reg.on) begin
      if (st_reg.cnt == '0) begin
        st_next.on = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.on;

endmodule : wdrt_pulse

// [wdrt_top.sv]
// Watchdog reset timer with AHB-Lite register access and reset-out.
// Assumes hclk is the oscillator (40 MHz); power-down and wake pins async.
//
// Functional notes
// - Fourteen-bit counter, disabled and stopped after reset.
// - Writing 1E then E1 to the key register arms the watchdog.
// - When armed the counter advances once every machine cycle.
// - A machine cycle is twelve oscillator periods.
// - Software cannot disarm; only hardware or overflow reset does.
// - Key sequence while armed clears the counter to zero.
// - Counter reaching 3FFF overflows and resets the device.
// - Overflow drives a high reset pulse of 98 oscillator periods.
// - Key register write-only; counter neither readable nor writable.
// - In power-down the counter holds and does not advance.
// - After interrupt wake, counting waits until the wake pin rises.
// - Idle keeps counting; software wakes periodically to service.
//
// Register access over AHB-Lite is this design's own decision.
`include "wdrt_cfg.svh"

module wdrt_top
  import wdrt_pkg::*;
#(
  parameter int unsigned CNT_WIDTH   = `WDRT_CNT_WIDTH,
  parameter int unsigned MCYCLE_OSC  = `WDRT_OSC_PER_MCYCLE,
  parameter int unsigned PULSE_OSC   = `WDRT_RST_PULSE_OSC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Power state pins
  input  wire logic        power_down,
  input  wire logic        wake_int_n,
  // Reset out
  output logic             reset_out,
  output logic             device_reset
);

  localparam int unsigned PW = $clog2(MCYCLE_OSC);

  // Whole state of the block except the pulse stretcher
  typedef struct packed {
    wdrt_bus_t            bus;
    wdrt_key_t            key;
    logic                 armed;
    logic [CNT_WIDTH-1:0] count;
    logic [PW-1:0]        phase;
    logic                 hold_wake;
    logic                 ovf;
    logic [1:0]           pd_sync;
    logic [1:0]           wk_sync;
    logic                 pd_seen;
    logic                 dev_rst;
  } wdrt_st_t;

  wdrt_st_t st_reg;
  wdrt_st_t st_next;

  logic pulse_q;
  logic take;
  logic wr_key;
  logic run;
  logic [7:0] wbyte;

  // Address phase accepted
  assign take = hsel & hready & htrans[1];

  // Key byte from the data phase
  assign wbyte  = hwdata[7:0];
  assign wr_key = st_reg.bus.pend & st_reg.bus.write &
                  (st_reg.bus.addr == `WDRT_SERVICE_KEY_OFF);

  // Counting enabled: armed, oscillator running, not held after wake
  // Idle leaves the oscillator running, so nothing here stops counting
  assign run = st_reg.armed & ~st_reg.pd_sync[1] & ~st_reg.hold_wake;

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.ovf = 1'b0;
    st_next.dev_rst = 1'b0;

    // Pin synchronisers
    st_next.pd_sync = {st_reg.pd_sync[0], power_down};
    st_next.wk_sync = {st_reg.wk_sync[0], wake_int_n};
    st_next.pd_seen = st_reg.pd_sync[1];

    // Bus capture: zero wait state slave
    st_next.bus.pend = take;
    if (take) begin
      st_next.bus.write = hwrite;
      st_next.bus.addr  = haddr[11:0];
    end

    // Read data; the key register and counter stay hidden
    st_next.bus.rdata = '0;
    if (take && !hwrite) begin
      unique case (haddr[11:0])
        `WDRT_STATUS_OFF: begin
          st_next.bus.rdata[`WDRT_STS_ARMED_BIT]   = st_reg.armed;
          st_next.bus.rdata[`WDRT_STS_HALTED_BIT]  = st_reg.pd_sync[1];
          st_next.bus.rdata[`WDRT_STS_PULSE_BIT]   = pulse_q;
          st_next.bus.rdata[`WDRT_STS_KEYHALF_BIT] =
            (st_reg.key == WDRT_KEY_HALF);
        end
        `WDRT_CONTROL_OFF: begin
          st_next.bus.rdata[`WDRT_CTL_WAKE_BIT] = st_reg.hold_wake;
        end
        default: begin
          st_next.bus.rdata = '0;
        end
      endcase
    end

    // Power-down exit by interrupt: hold until the pin goes high
    if (st_reg.pd_seen && !st_reg.pd_sync[1] && !st_reg.wk_sync[1]) begin
      st_next.hold_wake = 1'b1;
    end
    if (st_reg.hold_wake && st_reg.wk_sync[1]) begin
      st_next.hold_wake = 1'b0;
    end

    // Key sequence: a key register write other than E1 or 1E, or any write elsewhere, discards a half
    if (wr_key) begin
      unique case (st_reg.key)
        WDRT_KEY_IDLE: begin
          if (wbyte == `WDRT_KEY_FIRST) begin
            st_next.key = WDRT_KEY_HALF;
          end
        end
        WDRT_KEY_HALF: begin
          st_next.key = WDRT_KEY_IDLE;
          if (wbyte == `WDRT_KEY_SECOND) begin
            st_next.armed = 1'b1;
            st_next.count = '0;
            st_next.phase = '0;
          end else if (wbyte == `WDRT_KEY_FIRST) begin
            st_next.key = WDRT_KEY_HALF;
          end
        end
      endcase
    end else if (st_reg.bus.pend && st_reg.bus.write) begin
      st_next.key = WDRT_KEY_IDLE;
    end

    // Machine-cycle prescaler and counter
    if (run && !(wr_key && st_reg.key == WDRT_KEY_HALF &&
                 wbyte == `WDRT_KEY_SECOND)) begin
      if (st_reg.phase == PW'(MCYCLE_OSC - 1)) begin
        st_next.phase = '0;
        st_next.count = st_reg.count + CNT_WIDTH'(1);
        if (st_reg.count == CNT_WIDTH'(`WDRT_CNT_TERMINAL - 1)) begin
          st_next.ovf = 1'b1;
        end
      end else begin
        st_next.phase = st_reg.phase + PW'(1);
      end
    end
    // Power-down holds count and phase

    // Overflow resets the watchdog to disabled; software has no path
    if (st_reg.ovf) begin
      st_next.armed   = 1'b0;
      st_next.count   = '0;
      st_next.phase   = '0;
      st_next.key     = WDRT_KEY_IDLE;
      st_next.dev_rst = 1'b1;
    end
  end

  // State register; disabled from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Reset-out pulse stretcher
  wdrt_pulse #(
    .LENGTH (PULSE_OSC)
  ) u_pulse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .trigger (st_reg.ovf),
    .pulse   (pulse_q)
  );

  // Outputs
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_reg.bus.rdata;
  assign reset_out    = pulse_q;
  assign device_reset = st_reg.dev_rst;

endmodule : wdrt_top

// [wdrt_top_asserts.sv]
// Checker: device reset, reset pulse and read-back of the watchdog.
// Bound onto wdrt_top; sees its ports only.
module wdrt_chk #(
  parameter int unsigned PULSE_OSC = 98
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hrdata,
  // Reset out
  input wire logic        reset_out,
  input wire logic        device_reset
);
  logic [15:0] plen;
  wire         rd = hsel && hready && htrans[1] && !hwrite;
  wire  [11:0] a  = haddr[11:0];

  // Length of the current reset pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) plen <= '0;
    else plen <= reset_out ? plen + 16'd1 : '0;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Reset pulse and device reset
  pulse_len_a: assert property ($fell(reset_out) |-> plen == PULSE_OSC)
    else $error("reset pulse length wrong");
  pulse_max_a: assert property (plen <= PULSE_OSC)
    else $error("reset pulse too long");
  rise_dev_a: assert property ($rose(reset_out) |-> device_reset)
    else $error("no device reset at overflow");
  dev_rise_a: assert property (device_reset |-> $rose(reset_out))
    else $error("device reset without pulse");
  dev_once_a: assert property (device_reset |=> !device_reset)
    else $error("device reset too long");
  // Read-back
  key_read_a: assert property (rd && a == 12'h298 |=> hrdata == '0)
    else $error("key register readable");
  hole_read_a: assert property (rd && !(a inside {12'h298, 12'h100, 12'h104})
    |=> hrdata == '0) else $error("unmapped read not zero");
  sts_rsvd_a: assert property (rd && a == 12'h100 |=> hrdata[31:4] == '0)
    else $error("status spare bits set");

  // Main scenarios seen
  cover property (device_reset);
  cover property ($fell(reset_out));
  cover property (rd && a == 12'h298);
endmodule : wdrt_chk

bind wdrt_top wdrt_chk #(.PULSE_OSC(PULSE_OSC)) u_chk (.*);

// [tb_watchdog_reset_timer.sv]
// Bench for the watchdog reset timer over AHB-Lite.
// Assumes a four-bit counter for short runs and a 40 MHz hclk.
module tb_watchdog_reset_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0;
  logic        power_down = 0, wake_int_n = 1;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 0, hwdata = 0, rdat, hrdata;
  logic        hready, hreadyout, hresp, reset_out, device_reset;
  int          err_total = 0, n_compared = 0, npul = 0, hi = 0, n;

  // Clock, single-slave ready, pulse monitors
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;
  always @(posedge hclk) begin
    if (device_reset === 1'b1) npul++;
    if (reset_out === 1'b1) hi++;
  end

  wdrt_top #(.CNT_WIDTH(4)) uut (.*);

  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, d);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask : xfer

  task automatic key();
    xfer(1, 32'h0000_0298, 32'h0000_001e);
    xfer(1, 32'h0000_0298, 32'h0000_00e1);
  endtask : key

  task automatic sts(input logic armed);
    xfer(0, 32'h0000_0100, 0);
    chk(rdat[0], armed, "armed");
  endtask : sts

  task automatic do_reset();
    hresetn <= 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
  endtask : do_reset

  task automatic wait_ovf();
    n = 0;
    while (device_reset !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_ovf

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // Watchdog on the run itself
  initial begin
    repeat (6000) @(posedge hclk);
    err_total++;
    give_verdict();
  end

  initial begin
    do_reset();
    sts(0);
    xfer(0, 32'h0000_0298, 0);
    chk(rdat, 0, "key read");
    xfer(0, 32'h0000_0200, 0);
    chk(rdat, 0, "hole read");
    // Broken key halves must not arm
    xfer(1, 32'h0000_0298, 32'h0000_001e);
    xfer(1, 32'h0000_0200, 32'h0000_00e1);
    xfer(1, 32'h0000_0298, 32'h0000_00e1);
    xfer(1, 32'h0000_0298, 32'h0000_001e);
    xfer(1, 32'h0000_0298, 32'h0000_0055);
    xfer(1, 32'h0000_0298, 32'h0000_00e1);
    sts(0);
    key();
    sts(1);
    xfer(1, 32'h0000_0298, 0);
    xfer(1, 32'h0000_0298, 32'h0000_00e1);
    sts(1);
    // Service just in time, four times over, as idle software would
    repeat (4) begin
      repeat (150) @(posedge hclk);
      key();
    end
    chk(npul, 0, "serviced pulses");
    // Power down, then wake held by the interrupt pin
    power_down <= 1;
    repeat (400) @(posedge hclk);
    wake_int_n <= 0;
    repeat (4) @(posedge hclk);
    power_down <= 0;
    repeat (400) @(posedge hclk);
    chk(npul, 0, "held pulses");
    xfer(0, 32'h0000_0104, 0);
    chk(rdat[1], 1, "wake hold");
    wake_int_n <= 1;
    wait_ovf();
    chk(n > 150 && n < 200, 1, "wake overflow");
    // Fresh arm: overflow time and pulse length
    repeat (120) @(posedge hclk);
    sts(0);
    hi = 0;
    key();
    wait_ovf();
    chk(n >= 180 && n <= 186, 1, "overflow time");
    repeat (110) @(posedge hclk);
    chk(hi, 98, "pulse length");
    chk(npul, 2, "pulse count");
    // Hardware reset disarms
    key();
    repeat (50) @(posedge hclk);
    do_reset();
    sts(0);
    repeat (250) @(posedge hclk);
    chk(npul, 2, "after reset");
    give_verdict();
  end
endmodule : tb_watchdog_reset_timer
